// file: bmc_control.sv
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
module bmc_control #(
    parameter int BIT_DIV = bmc_pkg::BITDIV_DEF // Clocks per bit time
) (
    input  wire logic        clk,           // System clock
    input  wire logic        reset,         // Sync reset
    input  wire logic [7:0]  s_awaddr,      // Write address
    input  wire logic        s_awvalid,     // Address valid
    output logic             s_awready,     // Address ready
    input  wire logic [31:0] s_wdata,       // Write data
    input  wire logic [3:0]  s_wstrb,       // Byte enables
    input  wire logic        s_wvalid,      // Data valid
    output logic             s_wready,      // Data ready
    output logic [1:0]       s_bresp,       // Write response
    output logic             s_bvalid,      // Response valid
    input  wire logic        s_bready,      // Response ready
    input  wire logic [7:0]  s_araddr,      // Read address
    input  wire logic        s_arvalid,     // Read addr valid
    output logic             s_arready,     // Read addr ready
    output logic [31:0]      s_rdata,       // Read data
    output logic [1:0]       s_rresp,       // Read response
    output logic             s_rvalid,      // Read valid
    input  wire logic        s_rready,      // Read ready
    input  bmc_pkg::bmc_link_t link,        // Protocol engine status
    input  wire logic        loopback,      // Loopback mode
    input  wire logic        tx_empty,      // All transmit buffers empty
    input  wire logic        cpu_wait,      // CPU in wait, async
    input  wire logic        cpu_stop,      // CPU in stop, async
    output logic             transmit_pin,  // Line to transceiver
    output logic             proto_abort,   // Abort traffic, level
    output logic             core_clk_en,   // Interface clock enable
    output logic [15:0]      stamp_value    // Stamp for buffer top bytes
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctl0;       // Register contents
        logic       init_ak;    // Init acknowledge
        logic       sleep_ak;   // Sleep acknowledge
        logic [1:0] wait_sy;    // Wait synchroniser
        logic [1:0] stop_sy;    // Stop synchroniser
        logic       receiver_active_q;    // Sampled receiver active
        logic       sync_q;     // Sampled synchronized
        logic       txq;        // Registered transmit level
    } bmc_ctl_st_t;

    bmc_ctl_st_t      st_reg;
    bmc_ctl_st_t      st_next;
    bmc_pkg::bmc_wr_t wr;            // Write strobe from bus
    logic [7:0]       rd_addr;       // Read address
    logic [31:0]      rd_word;       // Read word
    logic             rd_hit;        // Mapped address
    logic             in_init;       // Request and acknowledge
    logic             in_sleep;      // Sleep entered
    logic             wait_gate;     // Wait stops the module
    logic             force_rec;     // Force recessive level
    logic [15:0]      tmr_count;     // Live timer
    logic [15:0]      tmr_stamp;     // Captured stamp

    assign in_init   = st_reg.ctl0[bmc_pkg::INIT_REQUEST_BIT] && st_reg.init_ak;
    assign in_sleep  = st_reg.ctl0[bmc_pkg::SLEEP_REQUEST_BIT] && st_reg.sleep_ak;
    // Only the synchronised copies are read here
    assign wait_gate = st_reg.wait_sy[1]
                       && st_reg.ctl0[bmc_pkg::STOP_IN_WAIT_BIT];
    // Recessive is one; protocol violation is avoided at once
    assign force_rec = wait_gate || st_reg.stop_sy[1]
                       || st_reg.ctl0[bmc_pkg::INIT_REQUEST_BIT];

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    bmc_axi_slave u_axi (
        .clk       (clk),
        .reset     (reset),
        .s_awaddr  (s_awaddr),
        .s_awvalid (s_awvalid),
        .s_awready (s_awready),
        .s_wdata   (s_wdata),
        .s_wstrb   (s_wstrb),
        .s_wvalid  (s_wvalid),
        .s_wready  (s_wready),
        .s_bresp   (s_bresp),
        .s_bvalid  (s_bvalid),
        .s_bready  (s_bready),
        .s_araddr  (s_araddr),
        .s_arvalid (s_arvalid),
        .s_arready (s_arready),
        .s_rdata   (s_rdata),
        .s_rresp   (s_rresp),
        .s_rvalid  (s_rvalid),
        .s_rready  (s_rready),
        .wr        (wr),
        .rd_addr   (rd_addr),
        .rd_word   (rd_word),
        .rd_hit    (rd_hit)
    );

    // ------------------------------------------------------------
    // Timestamp counter
    // ------------------------------------------------------------
    bmc_stamp_timer #(
        .BIT_DIV (BIT_DIV)
    ) u_tmr (
        .clk     (clk),
        .reset   (reset),
        .enable  (st_reg.ctl0[bmc_pkg::TIME_BIT]),
        .run     (!wait_gate),
        .capture (link.frame_acked),
        .count   (tmr_count),
        .stamp   (tmr_stamp)
    );

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (rd_addr)
            bmc_pkg::CTL0_ADDR: begin
                rd_word[7:0] = st_reg.ctl0;
            end
            bmc_pkg::CTL1_ADDR: begin
                rd_word[bmc_pkg::SLEEP_ACKNOWLEDGE_BIT]  = st_reg.sleep_ak;
                rd_word[bmc_pkg::INIT_ACKNOWLEDGE_BIT] = st_reg.init_ak;
            end
            bmc_pkg::TSTAMP_ADDR: begin
                rd_word[15:0] = tmr_stamp;
            end
            bmc_pkg::TIMER_ADDR: begin
                rd_word[15:0] = tmr_count;
            end
            default: begin          // Unmapped answers an error
                rd_hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Register and mode logic
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        // Two stages before any logic looks at the CPU mode pins
        st_next.wait_sy = {st_reg.wait_sy[0], cpu_wait};
        st_next.stop_sy = {st_reg.stop_sy[0], cpu_stop};
        // Status sampled each clock for stable reads
        st_next.receiver_active_q = link.rx_busy;
        st_next.sync_q  = link.bus_sync && !st_reg.ctl0[bmc_pkg::INIT_REQUEST_BIT];
        st_next.ctl0[bmc_pkg::RECEIVER_ACTIVE_BIT] = st_reg.receiver_active_q;
        st_next.ctl0[bmc_pkg::SYNC_BIT]  = st_reg.sync_q;
        st_next.txq = force_rec ? 1'b1 : link.tx_bits;

        // Software writes, only while neither init request nor init acknowledge is set, except the init request bit
        if (wr.wr_ctl0) begin
            if (!st_reg.ctl0[bmc_pkg::INIT_REQUEST_BIT] && !st_reg.init_ak) begin
                st_next.ctl0[bmc_pkg::STOP_IN_WAIT_BIT] =
                    wr.wr_data[bmc_pkg::STOP_IN_WAIT_BIT];
                st_next.ctl0[bmc_pkg::TIME_BIT] =
                    wr.wr_data[bmc_pkg::TIME_BIT];
                st_next.ctl0[bmc_pkg::WAKEUP_ENABLE_BIT] =
                    wr.wr_data[bmc_pkg::WAKEUP_ENABLE_BIT];
                // Write one clears the frame flag
                if (wr.wr_data[bmc_pkg::FRAME_RECEIVED_FLAG_BIT]) begin
                    st_next.ctl0[bmc_pkg::FRAME_RECEIVED_FLAG_BIT] = 1'b0;
                end
                // Sleep cannot be dropped until acknowledged
                if (wr.wr_data[bmc_pkg::SLEEP_REQUEST_BIT] || in_sleep ||
                    !st_reg.ctl0[bmc_pkg::SLEEP_REQUEST_BIT]) begin
                    st_next.ctl0[bmc_pkg::SLEEP_REQUEST_BIT] =
                        wr.wr_data[bmc_pkg::SLEEP_REQUEST_BIT];
                end
            end
            // Init request writable in init too; cleared only once in
            if (wr.wr_data[bmc_pkg::INIT_REQUEST_BIT] || in_init ||
                !st_reg.ctl0[bmc_pkg::INIT_REQUEST_BIT]) begin
                st_next.ctl0[bmc_pkg::INIT_REQUEST_BIT] =
                    wr.wr_data[bmc_pkg::INIT_REQUEST_BIT];
            end
        end

        // Valid frame sets the flag, filters play no part
        // Placed after the clear so the set wins
        // In loopback the flag simply tracks the engine
        if (link.rx_frame_ok) begin
            st_next.ctl0[bmc_pkg::FRAME_RECEIVED_FLAG_BIT] = 1'b1;
        end

        // Init acknowledge follows request; abort is immediate
        st_next.init_ak = st_reg.ctl0[bmc_pkg::INIT_REQUEST_BIT];

        // Sleep acknowledged only when the bus is quiet
        if (!st_reg.ctl0[bmc_pkg::SLEEP_REQUEST_BIT]) begin
            st_next.sleep_ak = 1'b0;
        end else if (!st_reg.sleep_ak && link.bus_idle &&
                     !link.rx_busy && tx_empty) begin
            st_next.sleep_ak = 1'b1;
        end

        // Bus traffic wakes the controller only if enabled
        if (in_sleep && link.bus_activity &&
            st_reg.ctl0[bmc_pkg::WAKEUP_ENABLE_BIT]) begin
            st_next.ctl0[bmc_pkg::SLEEP_REQUEST_BIT] = 1'b0;
            st_next.sleep_ak = 1'b0;
        end

        // Held at reset value in init, three bits kept
        if (in_init) begin
            st_next.ctl0[bmc_pkg::FRAME_RECEIVED_FLAG_BIT] = 1'b0;
            st_next.ctl0[bmc_pkg::RECEIVER_ACTIVE_BIT] = 1'b0;
            st_next.ctl0[bmc_pkg::STOP_IN_WAIT_BIT] = 1'b0;
            st_next.ctl0[bmc_pkg::SYNC_BIT]  = 1'b0;
            st_next.ctl0[bmc_pkg::TIME_BIT]  = 1'b0;
        end

        if (reset) begin
            st_next         = '0;
            st_next.ctl0    = bmc_pkg::CTL0_RESET;
            st_next.txq     = 1'b1;
        end
    end

    // Register the state
    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign transmit_pin = st_reg.txq;
    // Engine abort held while init is requested
    assign proto_abort  = st_reg.ctl0[bmc_pkg::INIT_REQUEST_BIT];
    // Clock enable for the interface; gated in wait mode
    assign core_clk_en  = !wait_gate;
    assign stamp_value  = tmr_stamp;

endmodule : bmc_control

// file: bmc_pkg.sv
package bmc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTL0_ADDR    = 8'h00; // Control register zero
    localparam logic [7:0] CTL1_ADDR    = 8'h04; // Acknowledge status
    localparam logic [7:0] TSTAMP_ADDR  = 8'h08; // Last captured stamp
    localparam logic [7:0] TIMER_ADDR   = 8'h0c; // Live counter value

    // ------------------------------------------------------------
    // Field positions of control register zero
    // ------------------------------------------------------------
    localparam int FRAME_RECEIVED_FLAG_BIT  = 7; // Received frame flag
    localparam int RECEIVER_ACTIVE_BIT  = 6; // Receiver active
    localparam int STOP_IN_WAIT_BIT  = 5; // Stop in wait
    localparam int SYNC_BIT   = 4; // Bus synchronized
    localparam int TIME_BIT   = 3; // Timer enable
    localparam int WAKEUP_ENABLE_BIT   = 2; // Wake-up enable
    localparam int SLEEP_REQUEST_BIT  = 1; // Sleep request
    localparam int INIT_REQUEST_BIT = 0; // Init request

    // Acknowledge register fields
    localparam int SLEEP_ACKNOWLEDGE_BIT  = 1; // Sleep acknowledge
    localparam int INIT_ACKNOWLEDGE_BIT = 0; // Init acknowledge

    // ------------------------------------------------------------
    // Reset values and widths
    // ------------------------------------------------------------
    localparam logic [7:0] CTL0_RESET  = 8'h01; // Init request set
    localparam int         TIMER_W     = 16;    // Timestamp width
    localparam int         BITDIV_DEF  = 50;    // Clocks per bit time

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0; // Normal answer
    localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped address, or a write to any address but ctl0

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        rx_frame_ok;   // Valid frame completed, pulse
        logic        rx_busy;       // Receiving, level
        logic        bus_sync;      // Synchronized, level
        logic        bus_idle;      // Idle bus, level
        logic        bus_activity;  // Dominant edge seen, pulse
        logic        frame_acked;   // Frame acknowledged, pulse
        logic        tx_bits;       // Protocol transmit level
    } bmc_link_t;

    typedef struct packed {
        logic [7:0]  wr_data;       // Byte written
        logic        wr_ctl0;       // Write strobe ctl0
    } bmc_wr_t;

endpackage : bmc_pkg

// file: bmc_axi_slave.sv
module bmc_axi_slave (
    input  wire logic        clk,           // System clock
    input  wire logic        reset,         // Sync reset
    input  wire logic [7:0]  s_awaddr,      // Write address
    input  wire logic        s_awvalid,     // Address valid
    output logic             s_awready,     // Address ready
    input  wire logic [31:0] s_wdata,       // Write data
    input  wire logic [3:0]  s_wstrb,       // Byte enables
    input  wire logic        s_wvalid,      // Data valid
    output logic             s_wready,      // Data ready
    output logic [1:0]       s_bresp,       // Write response
    output logic             s_bvalid,      // Response valid
    input  wire logic        s_bready,      // Response ready
    input  wire logic [7:0]  s_araddr,      // Read address
    input  wire logic        s_arvalid,     // Read addr valid
    output logic             s_arready,     // Read addr ready
    output logic [31:0]      s_rdata,       // Read data
    output logic [1:0]       s_rresp,       // Read response
    output logic             s_rvalid,      // Read valid
    input  wire logic        s_rready,      // Read ready
    output bmc_pkg::bmc_wr_t wr,            // Register write strobe
    output logic [7:0]       rd_addr,       // Read address to decode
    input  wire logic [31:0] rd_word,       // Decoded read word
    input  wire logic        rd_hit         // Read address mapped
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic        aw_got;   // Address held
        logic [7:0]  aw;       // Held address
        logic        w_got;    // Data held
        logic [7:0]  wd;       // Held low byte
        logic        wb;       // Low lane enabled
        logic        bvalid;   // Write answer pending
        logic [1:0]  bresp;    // Write answer
        logic        rvalid;   // Read answer pending
        logic [31:0] rdata;    // Read answer data
        logic [1:0]  rresp;    // Read answer code
    } bmc_axi_st_t;

    bmc_axi_st_t st_reg;
    bmc_axi_st_t st_next;
    logic        do_wr;    // Both halves present

    // Ready while the halves are not yet held and no write answer is pending
    assign s_awready = !st_reg.aw_got && !st_reg.bvalid;
    assign s_wready  = !st_reg.w_got && !st_reg.bvalid;
    assign s_arready = !st_reg.rvalid;
    assign s_bvalid  = st_reg.bvalid;
    assign s_bresp   = st_reg.bresp;
    assign s_rvalid  = st_reg.rvalid;
    assign s_rdata   = st_reg.rdata;
    assign s_rresp   = st_reg.rresp;
    assign rd_addr   = s_araddr;
    assign do_wr     = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
    assign wr.wr_data = st_reg.wd;
    assign wr.wr_ctl0 = do_wr && st_reg.wb
                        && (st_reg.aw[7:2] == bmc_pkg::CTL0_ADDR[7:2]);

    // ------------------------------------------------------------
    // Channel sequencing
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        if (s_awvalid && s_awready) begin   // Take address
            st_next.aw_got = 1'b1;
            st_next.aw     = s_awaddr;
        end
        if (s_wvalid && s_wready) begin     // Take data
            st_next.w_got = 1'b1;
            st_next.wd    = s_wdata[7:0];
            st_next.wb    = s_wstrb[0];
        end
        if (do_wr) begin                    // Answer after both
            st_next.aw_got = 1'b0;
            st_next.w_got  = 1'b0;
            st_next.bvalid = 1'b1;
            // Only ctl0 is writable; the rest answer an error
            st_next.bresp  = (st_reg.aw[7:2] == bmc_pkg::CTL0_ADDR[7:2])
                             ? bmc_pkg::RESP_OKAY : bmc_pkg::RESP_SLVERR;
        end
        if (st_reg.bvalid && s_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (s_arvalid && s_arready) begin   // Read captured at once
            st_next.rvalid = 1'b1;
            st_next.rdata  = rd_hit ? rd_word : 32'h0000_0000;
            st_next.rresp  = rd_hit ? bmc_pkg::RESP_OKAY
                                    : bmc_pkg::RESP_SLVERR;
        end else if (st_reg.rvalid && s_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (reset) begin
            st_next = '0;
        end
    end

    // Register the state
    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

endmodule : bmc_axi_slave

// file: bmc_stamp_timer.sv
module bmc_stamp_timer #(
    parameter int BIT_DIV = bmc_pkg::BITDIV_DEF // Clocks per bit time
) (
    input  wire logic                        clk,     // System clock
    input  wire logic                        reset,   // Sync reset
    input  wire logic                        enable,  // Timer enable
    input  wire logic                        run,     // Clock not gated
    input  wire logic                        capture, // Ack pulse
    output logic [bmc_pkg::TIMER_W-1:0]      count,   // Live value
    output logic [bmc_pkg::TIMER_W-1:0]      stamp    // Captured value
);

    localparam int DW = (BIT_DIV > 1) ? $clog2(BIT_DIV) : 1; // Divider width

    // Refuse a divider the logic cannot count, at elaboration
    if (BIT_DIV < 1) begin : g_div_bad
        $error("BIT_DIV must be at least one");
    end

    typedef struct packed {
        logic [DW-1:0]               div;   // Bit clock divider
        logic [bmc_pkg::TIMER_W-1:0] cnt;   // Free running count
        logic [bmc_pkg::TIMER_W-1:0] stp;   // Last stamp
    } bmc_tmr_st_t;

    bmc_tmr_st_t st_reg;
    bmc_tmr_st_t st_next;
    logic        tick;      // One pulse per bit time

    assign tick  = (st_reg.div == DW'(BIT_DIV - 1));
    assign count = st_reg.cnt;
    assign stamp = st_reg.stp;

    // ------------------------------------------------------------
    // Counter at bit rate
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        if (!enable) begin                  // Cleared while off
            st_next.div = '0;
            st_next.cnt = '0;
        end else if (run) begin
            st_next.div = tick ? '0 : st_reg.div + DW'(1);
            if (tick) begin
                st_next.cnt = st_reg.cnt + 16'h0001;
            end
        end
        // Stamp taken into the buffer's two top bytes
        if (enable && capture) begin
            st_next.stp = st_reg.cnt;
        end
        if (reset) begin
            st_next = '0;
        end
    end

    // Register the state
    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

endmodule : bmc_stamp_timer

// file: bmc_ctl_checker.sv
module bmc_ctl_checker #(
    parameter int BIT_DIV = bmc_pkg::BITDIV_DEF // Clocks per bit time
) (
    input wire logic        clk,          // System clock
    input wire logic        reset,        // Sync reset
    input wire logic [7:0]  s_araddr,     // Read address
    input wire logic        s_arvalid,    // Read addr valid
    input wire logic        s_arready,    // Read addr ready
    input wire logic [31:0] s_rdata,      // Read data
    input wire logic [1:0]  s_rresp,      // Read response
    input wire logic        s_rvalid,     // Read valid
    input wire logic        cpu_wait,     // CPU in wait
    input wire logic        cpu_stop,     // CPU in stop
    input wire logic        transmit_pin, // Line to transceiver
    input wire logic        proto_abort,  // Abort level
    input wire logic        core_clk_en   // Interface clock enable
);
    // ------------------------------------------------------------
    // Properties, one clock domain
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_reset_state: assert property ($fell(reset) |-> proto_abort && transmit_pin) else $error("reset state wrong");
    chk_abort_recess: assert property (proto_abort |=> transmit_pin) else $error("pin driven while aborting");
    chk_stop_recess: assert property (cpu_stop [*4] |=> transmit_pin) else $error("pin driven in stop");
    chk_wait_recess: assert property (!core_clk_en |=> transmit_pin) else $error("pin driven in wait");
    // Two flops of synchronizer between wait and the gate
    chk_gate_cause: assert property (!core_clk_en |-> $past(cpu_wait, 2)) else $error("gated without wait");
    chk_wait_free: assert property (!cpu_wait [*3] |-> core_clk_en) else $error("gated outside wait");
    chk_rd_unmapped: assert property (s_arvalid && s_arready && s_araddr[7:4] != 4'h0 |=> s_rvalid && s_rresp == 2'h2 && s_rdata == 32'h0) else $error("unmapped read answered");
    chk_rd_answer: assert property (s_arvalid && s_arready |=> s_rvalid) else $error("read answer late");

    // Main scenarios reached
    cover property (!core_clk_en);
    cover property (cpu_stop [*4]);
    cover property (s_rvalid && s_rresp == 2'h2);
endmodule : bmc_ctl_checker

bind bmc_control bmc_ctl_checker #(.BIT_DIV(BIT_DIV)) u_chk (.clk, .reset,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .cpu_wait, .cpu_stop, .transmit_pin, .proto_abort, .core_clk_en);

// file: bmc_bus_model.sv
module bmc_bus_model (
    input  wire logic         clk,  // System clock
    output bmc_pkg::bmc_link_t link // Protocol status to controller
);
    timeunit 1ns;
    timeprecision 1ns;
    // Synchronized idle bus, recessive, until traffic
    initial link = 7'h19;
    // Frame of len cycles, then valid-frame and ack pulses
    task receive(input int len);
        link.bus_idle <= 1'b0;
        link.rx_busy <= 1'b1;
        repeat (len) @(posedge clk);
        link.rx_busy <= 1'b0;
        link.rx_frame_ok <= 1'b1;
        link.frame_acked <= 1'b1;
        @(posedge clk);
        link.rx_frame_ok <= 1'b0;
        link.frame_acked <= 1'b0;
        link.bus_idle <= 1'b1;
    endtask : receive
    // Dominant edge seen on an idle bus
    task wake();
        link.bus_activity <= 1'b1;
        @(posedge clk);
        link.bus_activity <= 1'b0;
    endtask : wake
    // Engine transmit level, zero is dominant
    task tx_level(input logic b);
        link.tx_bits <= b;
    endtask : tx_level
endmodule : bmc_bus_model

// file: testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BD = 2; // Short bit time keeps the run brief
    logic clk, reset, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
    logic s_bready, s_arvalid, s_arready, s_rvalid, s_rready, loopback;
    logic tx_empty, cpu_wait, cpu_stop, transmit_pin, proto_abort;
    logic core_clk_en;
    logic [7:0] s_awaddr, s_araddr, d;
    logic [31:0] s_wdata, s_rdata, rd_d;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp, rd_r, wr_r;
    logic [15:0] stamp_value;
    bmc_pkg::bmc_link_t link;
    int bad_count, compares;
    bmc_control #(.BIT_DIV(BD)) dut (.clk, .reset, .s_awaddr, .s_awvalid,
        .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
        .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
        .s_rresp, .s_rvalid, .s_rready, .link, .loopback, .tx_empty,
        .cpu_wait, .cpu_stop, .transmit_pin, .proto_abort, .core_clk_en,
        .stamp_value);
    bmc_bus_model partner (.clk, .link);
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Compare and count
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Bus write: address and data offered together, bready held
    task wr(input logic [7:0] a, input logic [7:0] v);
        s_awaddr <= a;
        s_wdata <= {24'h0, v};
        {s_awvalid, s_wvalid} <= 2'h3;
        do begin
            @(posedge clk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        wr_r = s_bresp;
    endtask : wr
    // Bus read: data and response taken where rvalid is seen
    task rd(input logic [7:0] a);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        rd_d = s_rdata;
        rd_r = s_rresp;
    endtask : rd
    // Control word after a write outside init, sync status added
    function logic [31:0] ctl_exp(input logic [7:0] w);
        return {24'h0, (w & 8'h2c) | 8'h10};
    endfunction : ctl_exp
    task results();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        results();
    end
    initial begin
        {reset, tx_empty, s_wstrb} = 6'h31;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h05;
        {loopback, cpu_wait, cpu_stop, s_awaddr, s_araddr} = '0;
        s_wdata = '0;
        void'($urandom(32'hba27));
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        rd(8'h00); chk("ctl0 reset", 32'h1, rd_d);
        wr(8'h00, 8'had); rd(8'h00); chk("ctl0 in init", 32'h1, rd_d);
        rd(8'h04); chk("init ack", 32'h1, rd_d);
        rd(8'h0c); chk("timer in init", 32'h0, rd_d);
        wr(8'h00, 8'h00); rd(8'h04); chk("init left", 32'h0, rd_d);
        $display("test init done");
        repeat (12) begin
            d = 8'($urandom) & 8'hac;
            wr(8'h00, d); rd(8'h00); chk("ctl0 rw", ctl_exp(d), rd_d);
        end
        rd(8'h40); chk("unmapped resp", 32'h2, 32'(rd_r));
        wr(8'h40, 8'hff); chk("unmapped wr", 32'h2, 32'(wr_r));
        wr(8'h00, 8'h00); wr(8'h00, 8'h08);
        repeat (40) @(posedge clk);
        rd(8'h0c);
        chk("timer runs", 32'h1,
            32'(rd_d >= 38 / BD && rd_d <= 50 / BD));
        $display("test register done");
        fork
            partner.receive(20);
            begin repeat (8) @(posedge clk); rd(8'h00); end
        join
        chk("receiving", 32'h58, rd_d);
        repeat (3) @(posedge clk);
        rd(8'h00); chk("frame flag", 32'h98, rd_d);
        rd(8'h08);
        chk("stamp taken", 32'h1, 32'(rd_d[15:0] != 16'h0));
        chk("stamp out", rd_d, {16'h0, stamp_value});
        wr(8'h00, 8'h08); rd(8'h00); chk("flag kept", 32'h98, rd_d);
        wr(8'h00, 8'h88); rd(8'h00); chk("flag clear", 32'h18, rd_d);
        $display("test frame done");
        partner.tx_level(1'b0);
        wr(8'h00, 8'h20);
        chk("pin follows", 32'h0, {31'h0, transmit_pin});
        cpu_wait <= 1'b1;
        repeat (4) @(posedge clk);
        chk("clock gated", 32'h0, {31'h0, core_clk_en});
        chk("pin in wait", 32'h1, {31'h0, transmit_pin});
        {cpu_wait, cpu_stop} <= 2'h1;
        repeat (6) @(posedge clk);
        cpu_stop <= 1'b0;
        repeat (4) @(posedge clk);
        $display("test wait done");
        tx_empty <= 1'b0;
        wr(8'h00, 8'h04); wr(8'h00, 8'h06);
        repeat (4) @(posedge clk);
        rd(8'h04); chk("sleep held", 32'h0, rd_d);
        tx_empty <= 1'b1;
        repeat (4) @(posedge clk);
        rd(8'h04); chk("sleep ack", 32'h2, rd_d);
        partner.wake();
        repeat (4) @(posedge clk);
        rd(8'h00); chk("woken", 32'h14, rd_d);
        wr(8'h00, 8'h0d);
        repeat (3) @(posedge clk);
        rd(8'h00); chk("init holds", 32'h05, rd_d & 32'h2f);
        rd(8'h0c); chk("timer cleared", 32'h0, rd_d);
        $display("test sleep and init done");
        results();
    end
endmodule : testbench
